/* File: common/esbc_pkg.sv */
// Constants, commands, states and config layout for the erase suspend and bus config block
package esbc_pkg;

	localparam int unsigned REF_CLK_MHZ = 250;
	localparam int unsigned NS_PER_US = 1000;

	// Factory image: 15=1, 14:12=000, 11=1, 10=1, 9:8=10, 7:4=1011, 3=1, 2=0, 1:0=11
	localparam logic [15:0] CFG_FACTORY = 16'h8EBB;
	localparam logic [15:0] CFG_ERASED = 16'hFFFF;

	localparam int unsigned CFG_FREEZE_BIT = 11;
	localparam int unsigned CFG_SSR_FREEZE_BIT = 10;
	localparam int unsigned CFG_MAP_LO = 8;
	localparam int unsigned CFG_LAT_LO = 4;
	localparam int unsigned CFG_DRV_LO = 12;
	localparam int unsigned CFG_BURST_LO = 0;

	localparam logic [4:0] LAT_BASE_CLOCKS = 5'h05;

	localparam logic [1:0] BURST_CODE_64 = 2'h1;
	localparam logic [1:0] BURST_CODE_16 = 2'h2;
	localparam logic [1:0] BURST_CODE_32 = 2'h3;
	localparam logic [6:0] BURST_BYTES_64 = 7'h40;
	localparam logic [6:0] BURST_BYTES_16 = 7'h10;
	localparam logic [6:0] BURST_BYTES_32 = 7'h20;
	localparam logic [6:0] BURST_BYTES_NONE = 7'h00;

	localparam logic [3:0] CMD_STATUS_READ = 4'h0;
	localparam logic [3:0] CMD_ERASE_SECTOR = 4'h1;
	localparam logic [3:0] CMD_ERASE_CHIP = 4'h2;
	localparam logic [3:0] CMD_PROGRAM = 4'h3;
	localparam logic [3:0] CMD_ERASE_SUSPEND = 4'h4;
	localparam logic [3:0] CMD_ERASE_RESUME = 4'h5;
	localparam logic [3:0] CMD_STATUS_CLEAR = 4'h6;
	localparam logic [3:0] CMD_SOFT_RESET = 4'h7;
	localparam logic [3:0] CMD_LOAD_VOLATILE = 4'h8;
	localparam logic [3:0] CMD_PROG_NONVOLATILE = 4'h9;
	localparam logic [3:0] CMD_ERASE_NONVOLATILE = 4'hA;
	localparam logic [3:0] CMD_PROT_SPACE_ENTRY = 4'hB;
	localparam logic [3:0] CMD_SECURE_ENTRY = 4'hC;
	localparam logic [3:0] CMD_SPACE_EXIT = 4'hD;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PROGRAM,
		ST_PROGRAM_FAIL,
		ST_SECTOR_ERASE,
		ST_CHIP_ERASE,
		ST_SUSPENDING,
		ST_ERASE_SUSPENDED,
		ST_SUSP_PROGRAM,
		ST_SUSP_PROGRAM_FAIL
	} esbc_state_t;

endpackage

/* File: rtl/esbc_erase_suspend_cfg.sv */
// Erase suspend sequencing and bus configuration registers behind a link-clocked command port
`timescale 1ns/1ns
`default_nettype none

module esbc_erase_suspend_cfg #(
	parameter int unsigned SUSPEND_LATENCY_NS = 40000
) (
	// Core clock and resets
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic por_nrst_i,
	// Link clock domain command port
	input wire logic link_clk_i,
	input wire logic link_nrst_i,
	input wire logic cmd_valid_i,
	input wire logic [3:0] cmd_code_i,
	input wire logic [7:0] cmd_sector_i,
	input wire logic [15:0] cmd_data_i,
	output logic cmd_ready_o,
	// Algorithm engine
	input wire logic erase_done_i,
	input wire logic program_done_i,
	input wire logic program_fail_i,
	output logic erase_run_o,
	output logic program_run_o,
	output logic secure_target_o,
	// Array read check
	input wire logic rd_valid_i,
	input wire logic [7:0] rd_sector_i,
	output logic rd_undefined_o,
	// Status
	output logic ready_o,
	output logic erase_suspended_o,
	output logic program_fail_o,
	output logic cmd_refused_o,
	output logic prot_space_o,
	// Bus configuration
	output logic [15:0] volatile_bus_config_o,
	output logic [15:0] nonvolatile_bus_config_o,
	output logic volatile_selected_o,
	output logic [6:0] burst_bytes_o,
	output logic [4:0] read_latency_o,
	output logic [2:0] drive_strength_o,
	output logic [1:0] sector_map_o,
	output logic cfg_frozen_o,
	output logic secure_frozen_o
);

	// Longest time, so rounded down, never below one cycle
	localparam int unsigned ESL_RAW = SUSPEND_LATENCY_NS * esbc_pkg::REF_CLK_MHZ / esbc_pkg::NS_PER_US;
	localparam int unsigned ESL_CYCLES = (ESL_RAW < 1) ? 1 : ESL_RAW;
	localparam logic [19:0] ESL_LOAD = 20'(ESL_CYCLES - 1);

	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic req_tgl;
		logic [3:0] code;
		logic [7:0] sector;
		logic [15:0] data;
		logic ack_s1;
		logic ack_s2;
	} esbc_link_t;

	typedef struct packed {
		esbc_pkg::esbc_state_t state;
		logic [15:0] volatile_bus_config;
		logic [15:0] nonvolatile_bus_config;
		logic vcr_loaded;
		logic [7:0] susp_sector;
		logic secure_mode;
		logic prot_mode;
		logic [19:0] lat_cnt;
		logic req_s1;
		logic req_s2;
		logic ack_tgl;
		logic refused;
		logic rd_undef;
	} esbc_core_t;

	esbc_link_t lk;
	esbc_link_t next_lk;
	esbc_core_t cr;
	esbc_core_t next_cr;

	function automatic logic in_suspend(input esbc_pkg::esbc_state_t s);
		in_suspend = (s == esbc_pkg::ST_ERASE_SUSPENDED) || (s == esbc_pkg::ST_SUSP_PROGRAM) ||
			(s == esbc_pkg::ST_SUSP_PROGRAM_FAIL);
	endfunction

	function automatic logic [6:0] burst_bytes(input logic [1:0] code);
		case (code)
			esbc_pkg::BURST_CODE_64: burst_bytes = esbc_pkg::BURST_BYTES_64;
			esbc_pkg::BURST_CODE_16: burst_bytes = esbc_pkg::BURST_BYTES_16;
			esbc_pkg::BURST_CODE_32: burst_bytes = esbc_pkg::BURST_BYTES_32;
			default: burst_bytes = esbc_pkg::BURST_BYTES_NONE;
		endcase
	endfunction

	// Link side: hold one command until the core echoes its toggle back
	always_comb begin
		next_lk = lk;
		// Link reset passes two flops so that its release is clean in the link domain
		next_lk.rst_s1 = link_nrst_i;
		next_lk.rst_s2 = lk.rst_s1;
		next_lk.ack_s1 = cr.ack_tgl;
		next_lk.ack_s2 = lk.ack_s1;
		if (!lk.rst_s2) begin
			next_lk.req_tgl = 1'b0;
			next_lk.code = 4'h0;
			next_lk.sector = 8'h00;
			next_lk.data = 16'h0000;
			next_lk.ack_s1 = 1'b0;
			next_lk.ack_s2 = 1'b0;
		end else if (cmd_valid_i && (lk.req_tgl == lk.ack_s2)) begin
			next_lk.req_tgl = ~lk.req_tgl;
			next_lk.code = cmd_code_i;
			next_lk.sector = cmd_sector_i;
			next_lk.data = cmd_data_i;
		end
	end

	always_ff @(posedge link_clk_i) begin
		lk <= next_lk;
	end

	assign cmd_ready_o = lk.rst_s2 && (lk.req_tgl == lk.ack_s2);

	// Core side
	always_comb begin
		logic accept;
		logic idle;
		logic unfrozen;
		accept = 1'b0;
		idle = (cr.state == esbc_pkg::ST_IDLE);
		unfrozen = cr.volatile_bus_config[esbc_pkg::CFG_FREEZE_BIT];
		next_cr = cr;
		next_cr.req_s1 = lk.req_tgl;
		next_cr.req_s2 = cr.req_s1;
		next_cr.refused = 1'b0;
		// Only one sector can be suspended at a time, so one compare is enough
		next_cr.rd_undef = rd_valid_i && in_suspend(cr.state) && (rd_sector_i == cr.susp_sector);

		case (cr.state)
			esbc_pkg::ST_PROGRAM: begin
				if (program_fail_i) begin
					next_cr.state = esbc_pkg::ST_PROGRAM_FAIL;
				end else if (program_done_i) begin
					next_cr.state = esbc_pkg::ST_IDLE;
				end
			end
			esbc_pkg::ST_SECTOR_ERASE, esbc_pkg::ST_CHIP_ERASE: begin
				if (erase_done_i) begin
					next_cr.state = esbc_pkg::ST_IDLE;
				end
			end
			esbc_pkg::ST_SUSPENDING: begin
				// Erase keeps running until the latency expires, then halts
				if (cr.lat_cnt == 20'h00000) begin
					next_cr.state = esbc_pkg::ST_ERASE_SUSPENDED;
				end else begin
					next_cr.lat_cnt = cr.lat_cnt - 20'h00001;
				end
			end
			esbc_pkg::ST_SUSP_PROGRAM: begin
				if (program_fail_i) begin
					next_cr.state = esbc_pkg::ST_SUSP_PROGRAM_FAIL;
				end else if (program_done_i) begin
					next_cr.state = esbc_pkg::ST_ERASE_SUSPENDED;
				end
			end
			default: begin
			end
		endcase

		// Code, sector and data stay put on the link side until the echo returns,
		// so the core may read them once the toggle has passed its two flops
		if (cr.req_s2 != cr.ack_tgl) begin
			next_cr.ack_tgl = cr.req_s2;
			case (lk.code)
				esbc_pkg::CMD_STATUS_READ: begin
					accept = 1'b1;
				end
				esbc_pkg::CMD_ERASE_SUSPEND: begin
					// Chip erase cannot be interrupted
					if (cr.state == esbc_pkg::ST_SECTOR_ERASE) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_SUSPENDING;
						next_cr.lat_cnt = ESL_LOAD;
					end else if (cr.state == esbc_pkg::ST_PROGRAM) begin
						accept = 1'b1;
					end
				end
				esbc_pkg::CMD_ERASE_RESUME: begin
					// A second resume finds the erase running and is dropped
					if (cr.state == esbc_pkg::ST_ERASE_SUSPENDED) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_SECTOR_ERASE;
					end
				end
				esbc_pkg::CMD_ERASE_SECTOR: begin
					if (idle) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_SECTOR_ERASE;
						next_cr.susp_sector = lk.sector;
					end
				end
				esbc_pkg::CMD_ERASE_CHIP: begin
					if (idle) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_CHIP_ERASE;
					end
				end
				esbc_pkg::CMD_PROGRAM: begin
					if (cr.secure_mode && !cr.volatile_bus_config[esbc_pkg::CFG_SSR_FREEZE_BIT]) begin
						accept = 1'b0;
					end else if (idle) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_PROGRAM;
					end else if (cr.state == esbc_pkg::ST_ERASE_SUSPENDED &&
						(cr.secure_mode || lk.sector != cr.susp_sector)) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_SUSP_PROGRAM;
					end
				end
				esbc_pkg::CMD_STATUS_CLEAR, esbc_pkg::CMD_SOFT_RESET: begin
					// Settings source selection is left alone here
					if (cr.state == esbc_pkg::ST_SUSP_PROGRAM_FAIL) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_ERASE_SUSPENDED;
					end else if (cr.state == esbc_pkg::ST_PROGRAM_FAIL || idle) begin
						accept = 1'b1;
						next_cr.state = esbc_pkg::ST_IDLE;
					end
					if (accept && lk.code == esbc_pkg::CMD_SOFT_RESET) begin
						next_cr.secure_mode = 1'b0;
						next_cr.prot_mode = 1'b0;
					end
				end
				esbc_pkg::CMD_SPACE_EXIT: begin
					if (idle || cr.state == esbc_pkg::ST_ERASE_SUSPENDED) begin
						accept = 1'b1;
						next_cr.secure_mode = 1'b0;
						next_cr.prot_mode = 1'b0;
					end
				end
				esbc_pkg::CMD_SECURE_ENTRY: begin
					if (idle || cr.state == esbc_pkg::ST_ERASE_SUSPENDED) begin
						accept = 1'b1;
						next_cr.secure_mode = 1'b1;
					end
				end
				esbc_pkg::CMD_PROT_SPACE_ENTRY: begin
					// Suspended or busy states keep the protection-bit space closed
					if (idle) begin
						accept = 1'b1;
						next_cr.prot_mode = 1'b1;
					end
				end
				esbc_pkg::CMD_LOAD_VOLATILE: begin
					// Freeze is read from the live copy
					if (idle && unfrozen) begin
						accept = 1'b1;
						next_cr.volatile_bus_config = lk.data;
						next_cr.vcr_loaded = 1'b1;
					end
				end
				esbc_pkg::CMD_PROG_NONVOLATILE: begin
					if (idle && unfrozen) begin
						accept = 1'b1;
						next_cr.nonvolatile_bus_config = lk.data;
						if (!cr.vcr_loaded) begin
							next_cr.volatile_bus_config = lk.data;
						end
					end
				end
				esbc_pkg::CMD_ERASE_NONVOLATILE: begin
					if (idle && unfrozen) begin
						accept = 1'b1;
						next_cr.nonvolatile_bus_config = esbc_pkg::CFG_ERASED;
					end
				end
				default: begin
				end
			endcase
			next_cr.refused = !accept;
		end

		if (!por_nrst_i || !nrst_i) begin
			next_cr.state = esbc_pkg::ST_IDLE;
			next_cr.vcr_loaded = 1'b0;
			next_cr.susp_sector = 8'h00;
			next_cr.secure_mode = 1'b0;
			next_cr.prot_mode = 1'b0;
			next_cr.lat_cnt = 20'h00000;
			// A command caught by a hard reset is echoed, so the link never replays it; all but a non-volatile program or erase are dropped
			next_cr.ack_tgl = cr.req_s2;
			next_cr.refused = 1'b0;
			next_cr.rd_undef = 1'b0;
			// Non-volatile copy survives a hard reset and becomes the live setting
			next_cr.volatile_bus_config = cr.nonvolatile_bus_config;
			if (!por_nrst_i) begin
				// Power-up clears both toggles together with the link's own reset
				next_cr.req_s1 = 1'b0;
				next_cr.req_s2 = 1'b0;
				next_cr.ack_tgl = 1'b0;
				next_cr.nonvolatile_bus_config = esbc_pkg::CFG_FACTORY;
				next_cr.volatile_bus_config = esbc_pkg::CFG_FACTORY;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		cr <= next_cr;
	end

	// The suspend latency window still counts as erasing
	assign erase_run_o = (cr.state == esbc_pkg::ST_SECTOR_ERASE) || (cr.state == esbc_pkg::ST_CHIP_ERASE) ||
		(cr.state == esbc_pkg::ST_SUSPENDING);
	assign program_run_o = (cr.state == esbc_pkg::ST_PROGRAM) || (cr.state == esbc_pkg::ST_SUSP_PROGRAM);
	assign secure_target_o = cr.secure_mode;
	assign rd_undefined_o = cr.rd_undef;
	assign ready_o = (cr.state == esbc_pkg::ST_IDLE) || (cr.state == esbc_pkg::ST_ERASE_SUSPENDED) ||
		(cr.state == esbc_pkg::ST_PROGRAM_FAIL) || (cr.state == esbc_pkg::ST_SUSP_PROGRAM_FAIL);
	assign erase_suspended_o = in_suspend(cr.state);
	assign program_fail_o = (cr.state == esbc_pkg::ST_PROGRAM_FAIL) || (cr.state == esbc_pkg::ST_SUSP_PROGRAM_FAIL);
	assign cmd_refused_o = cr.refused;
	assign prot_space_o = cr.prot_mode;

	assign volatile_bus_config_o = cr.volatile_bus_config;
	assign nonvolatile_bus_config_o = cr.nonvolatile_bus_config;
	assign volatile_selected_o = cr.vcr_loaded;
	assign burst_bytes_o = burst_bytes(cr.volatile_bus_config[esbc_pkg::CFG_BURST_LO +: 2]);
	assign read_latency_o = esbc_pkg::LAT_BASE_CLOCKS + {1'b0, cr.volatile_bus_config[esbc_pkg::CFG_LAT_LO +: 4]};
	assign drive_strength_o = cr.volatile_bus_config[esbc_pkg::CFG_DRV_LO +: 3];
	assign sector_map_o = cr.volatile_bus_config[esbc_pkg::CFG_MAP_LO +: 2];
	assign cfg_frozen_o = !cr.volatile_bus_config[esbc_pkg::CFG_FREEZE_BIT];
	assign secure_frozen_o = !cr.volatile_bus_config[esbc_pkg::CFG_SSR_FREEZE_BIT];

endmodule

`default_nettype wire

/* File: sim/esbc_host_model.sv */
// Host controller model driving the link-clocked command port
`timescale 1ns/1ns
`default_nettype none
module esbc_host_model (
	// Link side
	input wire logic link_clk_i,
	input wire logic cmd_ready_i,
	output logic cmd_valid_o,
	output logic [3:0] cmd_code_o,
	output logic [7:0] cmd_sector_o,
	output logic [15:0] cmd_data_o,
	// Bench status
	output logic timed_out_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o = 4'h0;
		cmd_sector_o = 8'h00;
		cmd_data_o = 16'h0000;
		timed_out_o = 1'b0;
	end
	task automatic wait_ready(input logic lvl);
		int n;
		for (n = 0; n < 200 && cmd_ready_i !== lvl; n++) @(posedge link_clk_i);
		if (cmd_ready_i !== lvl) timed_out_o = 1'b1;
	endtask
	// One command in flight; the next waits until the core hands ready back
	task automatic send(input logic [3:0] code, input logic [7:0] sec, input logic [15:0] data);
		@(posedge link_clk_i);
		wait_ready(1'b1);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= code;
		cmd_sector_o <= sec;
		cmd_data_o <= data;
		@(posedge link_clk_i);
		cmd_valid_o <= 1'b0;
		// Released lines carry the inverse so a stale request cannot pass
		cmd_code_o <= ~code;
		cmd_sector_o <= ~sec;
		cmd_data_o <= ~data;
		wait_ready(1'b0);
		wait_ready(1'b1);
	endtask
endmodule
`default_nettype wire

/* File: sim/esbc_asserts.sv */
// Port-level assertions for the erase suspend and bus config block
`timescale 1ns/1ns
`default_nettype none
module esbc_asserts #(
	parameter int unsigned SUSPEND_LATENCY_NS = 40000
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic por_nrst_i,
	input wire logic rd_valid_i,
	input wire logic rd_undefined_o,
	input wire logic erase_run_o,
	input wire logic ready_o,
	input wire logic erase_suspended_o,
	input wire logic cmd_refused_o,
	input wire logic [15:0] volatile_bus_config_o,
	input wire logic [15:0] nonvolatile_bus_config_o,
	input wire logic volatile_selected_o,
	input wire logic [6:0] burst_bytes_o,
	input wire logic [4:0] read_latency_o,
	input wire logic [2:0] drive_strength_o,
	input wire logic [1:0] sector_map_o,
	input wire logic cfg_frozen_o,
	input wire logic secure_frozen_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i || !por_nrst_i);
	run_not_idle_a: assert property (erase_run_o |-> !ready_o && !erase_suspended_o)
		else $error("erase running while idle");
	latency_decode_a: assert property (read_latency_o == {1'b0, volatile_bus_config_o[7:4]} + 5'h05)
		else $error("latency decode");
	burst_decode_a: assert property (burst_bytes_o == {volatile_bus_config_o[1:0] == 2'h1,
		volatile_bus_config_o[1:0] == 2'h3, volatile_bus_config_o[1:0] == 2'h2, 4'h0}) else $error("burst decode");
	field_copy_a: assert property ({drive_strength_o, sector_map_o} ==
		{volatile_bus_config_o[14:12], volatile_bus_config_o[9:8]}) else $error("field decode");
	freeze_flags_a: assert property ({cfg_frozen_o, secure_frozen_o} == ~volatile_bus_config_o[11:10])
		else $error("freeze flags");
	frozen_hold_a: assert property (cfg_frozen_o |=>
		$stable(volatile_bus_config_o) && $stable(nonvolatile_bus_config_o)) else $error("frozen copy changed");
	undef_read_a: assert property (rd_undefined_o |-> $past(rd_valid_i) && $past(erase_suspended_o))
		else $error("undefined flag without suspended read");
	select_hold_a: assert property (volatile_selected_o |=> volatile_selected_o)
		else $error("source select dropped");
	refuse_pulse_a: assert property (cmd_refused_o |=> !cmd_refused_o)
		else $error("refusal pulse too long");
endmodule
bind esbc_erase_suspend_cfg esbc_asserts #(.SUSPEND_LATENCY_NS(SUSPEND_LATENCY_NS)) u_chk (.ref_clk_i, .nrst_i,
	.por_nrst_i, .rd_valid_i, .rd_undefined_o, .erase_run_o, .ready_o, .erase_suspended_o, .cmd_refused_o,
	.volatile_bus_config_o, .nonvolatile_bus_config_o, .volatile_selected_o, .burst_bytes_o, .read_latency_o,
	.drive_strength_o, .sector_map_o, .cfg_frozen_o, .secure_frozen_o);
`default_nettype wire

/* File: sim/tb_erase_suspend_and_bus_config.sv */
// Self-checking bench for the erase suspend and bus config block
`timescale 1ns/1ns
`default_nettype none
module tb_erase_suspend_and_bus_config;
	logic ref_clk_i = 1'b0, link_clk_i = 1'b0, nrst_i = 1'b0, por_nrst_i = 1'b0, link_nrst_i = 1'b0;
	logic erase_done_i = 1'b0, program_done_i = 1'b0, program_fail_i = 1'b0, rd_valid_i = 1'b0;
	logic [7:0] rd_sector_i = 8'h00, cmd_sector_i;
	logic [3:0] cmd_code_i;
	logic [15:0] cmd_data_i, volatile_bus_config_o, nonvolatile_bus_config_o, v, n, m, refusals = 16'h0000, r0;
	logic cmd_valid_i, cmd_ready_o, erase_run_o, program_run_o, secure_target_o, rd_undefined_o, ready_o;
	logic erase_suspended_o, program_fail_o, cmd_refused_o, prot_space_o, volatile_selected_o, timed_out;
	logic cfg_frozen_o, secure_frozen_o;
	logic [6:0] burst_bytes_o;
	logic [4:0] read_latency_o;
	logic [2:0] drive_strength_o;
	logic [1:0] sector_map_o;
	int failures = 0, check_count = 0, i;
	always #2 ref_clk_i = ~ref_clk_i;
	always #32 link_clk_i = ~link_clk_i;
	always @(posedge ref_clk_i) if (cmd_refused_o === 1'b1) refusals <= refusals + 16'h0001;
	// Suspend latency shortened to 10 core cycles
	esbc_erase_suspend_cfg #(.SUSPEND_LATENCY_NS(40)) dut (.ref_clk_i, .nrst_i, .por_nrst_i, .link_clk_i,
		.link_nrst_i, .cmd_valid_i, .cmd_code_i, .cmd_sector_i, .cmd_data_i, .cmd_ready_o, .erase_done_i,
		.program_done_i, .program_fail_i, .erase_run_o, .program_run_o, .secure_target_o, .rd_valid_i,
		.rd_sector_i, .rd_undefined_o, .ready_o, .erase_suspended_o, .program_fail_o, .cmd_refused_o,
		.prot_space_o, .volatile_bus_config_o, .nonvolatile_bus_config_o, .volatile_selected_o, .burst_bytes_o,
		.read_latency_o, .drive_strength_o, .sector_map_o, .cfg_frozen_o, .secure_frozen_o);
	esbc_host_model host (.link_clk_i, .cmd_ready_i(cmd_ready_o), .cmd_valid_o(cmd_valid_i),
		.cmd_code_o(cmd_code_i), .cmd_sector_o(cmd_sector_i), .cmd_data_o(cmd_data_i), .timed_out_o(timed_out));
	task automatic stop_test;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [6:0] burst_of(input logic [1:0] c);
		case (c)
			2'h1: return 7'h40;
			2'h2: return 7'h10;
			2'h3: return 7'h20;
			default: return 7'h00;
		endcase
	endfunction
	task automatic cmd(input logic [3:0] c, input logic [7:0] s, input logic [15:0] d);
		host.send(c, s, d);
		if (timed_out === 1'b1) begin
			failures++;
			stop_test;
		end
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic check_cfg(input logic [15:0] e);
		chk(volatile_bus_config_o, e);
		chk(burst_bytes_o, burst_of(e[1:0]));
		chk(read_latency_o, {1'b0, e[7:4]} + 5'h05);
		chk({drive_strength_o, sector_map_o}, {e[14:12], e[9:8]});
		chk({cfg_frozen_o, secure_frozen_o}, {!e[11], !e[10]});
	endtask
	task automatic pulse(input logic [2:0] mask);
		@(posedge ref_clk_i);
		{program_fail_i, program_done_i, erase_done_i} <= mask;
		@(posedge ref_clk_i);
		{program_fail_i, program_done_i, erase_done_i} <= 3'h0;
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic hard_reset;
		@(posedge ref_clk_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask
	// Latency is 10 cycles; the bound leaves room for the crossing
	task automatic wait_susp;
		for (i = 0; i < 40 && erase_suspended_o !== 1'b1; i++) @(posedge ref_clk_i);
		chk(erase_suspended_o, 1'b1);
		chk({erase_run_o, ready_o}, 2'b01);
	endtask
	task automatic probe(input logic [7:0] sec, input logic exp);
		@(posedge ref_clk_i);
		rd_valid_i <= 1'b1;
		rd_sector_i <= sec;
		@(posedge ref_clk_i);
		rd_valid_i <= 1'b0;
		rd_sector_i <= ~sec;
		#1;
		chk(rd_undefined_o, exp);
	endtask
	initial begin
		void'($urandom(12236));
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		por_nrst_i <= 1'b1;
		repeat (4) @(posedge link_clk_i);
		link_nrst_i <= 1'b1;
		#1;
		check_cfg(16'h8EBB);
		chk({nonvolatile_bus_config_o, volatile_selected_o}, {16'h8EBB, 1'b0});
		for (int k = 0; k < 4; k++) begin
			v = 16'($urandom);
			v[11:10] = 2'b11;
			v[1:0] = 2'(k);
			if (k == 0) v[7:4] = 4'h0;
			cmd(esbc_pkg::CMD_LOAD_VOLATILE, 8'h00, v);
			check_cfg(v);
			chk({nonvolatile_bus_config_o, volatile_selected_o}, {16'h8EBB, 1'b1});
		end
		cmd(esbc_pkg::CMD_SOFT_RESET, 8'h00, 16'h0000);
		chk({volatile_bus_config_o, volatile_selected_o}, {v, 1'b1});
		n = 16'($urandom) | 16'h0C00;
		cmd(esbc_pkg::CMD_ERASE_NONVOLATILE, 8'h00, 16'h0000);
		cmd(esbc_pkg::CMD_PROG_NONVOLATILE, 8'h00, n);
		chk({nonvolatile_bus_config_o, volatile_bus_config_o}, {n, v});
		hard_reset;
		check_cfg(n);
		chk(volatile_selected_o, 1'b0);
		m = 16'($urandom) | 16'h0C00;
		cmd(esbc_pkg::CMD_ERASE_NONVOLATILE, 8'h00, 16'h0000);
		cmd(esbc_pkg::CMD_PROG_NONVOLATILE, 8'h00, m);
		chk(volatile_bus_config_o, m);
		r0 = refusals;
		cmd(esbc_pkg::CMD_LOAD_VOLATILE, 8'h00, m & 16'hF7FF);
		cmd(esbc_pkg::CMD_LOAD_VOLATILE, 8'h00, m ^ 16'h00F0);
		cmd(esbc_pkg::CMD_PROG_NONVOLATILE, 8'h00, 16'h0000);
		chk({volatile_bus_config_o, nonvolatile_bus_config_o}, {m & 16'hF7FF, m});
		chk(refusals - r0, 16'h0002);
		hard_reset;
		cmd(esbc_pkg::CMD_LOAD_VOLATILE, 8'h00, m & 16'hFBFF);
		cmd(esbc_pkg::CMD_PROT_SPACE_ENTRY, 8'h00, 16'h0000);
		chk(prot_space_o, 1'b1);
		cmd(esbc_pkg::CMD_SECURE_ENTRY, 8'h00, 16'h0000);
		chk({secure_target_o, prot_space_o}, 2'b11);
		r0 = refusals;
		cmd(esbc_pkg::CMD_PROGRAM, 8'h01, 16'h0000);
		chk({program_run_o, refusals - r0}, {1'b0, 16'h0001});
		cmd(esbc_pkg::CMD_SPACE_EXIT, 8'h00, 16'h0000);
		chk({secure_target_o, prot_space_o}, 2'b00);
		cmd(esbc_pkg::CMD_ERASE_SECTOR, 8'h05, 16'h0000);
		chk(erase_run_o, 1'b1);
		cmd(esbc_pkg::CMD_ERASE_SUSPEND, 8'h00, 16'h0000);
		wait_susp;
		probe(8'h05, 1'b1);
		probe(8'h06, 1'b0);
		cmd(esbc_pkg::CMD_PROGRAM, 8'h06, 16'h0000);
		chk(program_run_o, 1'b1);
		pulse(3'b010);
		chk({erase_suspended_o, program_run_o}, 2'b10);
		r0 = refusals;
		cmd(esbc_pkg::CMD_PROGRAM, 8'h05, 16'h0000);
		cmd(esbc_pkg::CMD_PROT_SPACE_ENTRY, 8'h00, 16'h0000);
		cmd(esbc_pkg::CMD_STATUS_READ, 8'h00, 16'h0000);
		cmd(esbc_pkg::CMD_ERASE_SECTOR, 8'h07, 16'h0000);
		chk({prot_space_o, refusals - r0}, {1'b0, 16'h0003});
		for (int k = 0; k < 2; k++) begin
			cmd(esbc_pkg::CMD_PROGRAM, 8'h06, 16'h0000);
			pulse(3'b100);
			chk(program_fail_o, 1'b1);
			cmd(k == 0 ? esbc_pkg::CMD_STATUS_CLEAR : esbc_pkg::CMD_SOFT_RESET, 8'h00, 16'h0000);
			chk({program_fail_o, erase_suspended_o}, 2'b01);
		end
		cmd(esbc_pkg::CMD_ERASE_RESUME, 8'h00, 16'h0000);
		chk({erase_run_o, erase_suspended_o}, 2'b10);
		r0 = refusals;
		cmd(esbc_pkg::CMD_ERASE_RESUME, 8'h00, 16'h0000);
		chk(refusals - r0, 16'h0001);
		cmd(esbc_pkg::CMD_ERASE_SUSPEND, 8'h00, 16'h0000);
		wait_susp;
		cmd(esbc_pkg::CMD_ERASE_RESUME, 8'h00, 16'h0000);
		pulse(3'b001);
		chk(ready_o, 1'b1);
		cmd(esbc_pkg::CMD_ERASE_CHIP, 8'h00, 16'h0000);
		r0 = refusals;
		cmd(esbc_pkg::CMD_ERASE_SUSPEND, 8'h00, 16'h0000);
		repeat (20) @(posedge ref_clk_i);
		chk({erase_run_o, erase_suspended_o, refusals - r0}, {2'b10, 16'h0001});
		pulse(3'b001);
		chk(ready_o, 1'b1);
		stop_test;
	end
endmodule
`default_nettype wire
